// [prsd_consts.svh]
// Purpose: constants for the clock ratio strap decoder
// Assumes: included by its bare name
// Notes: ratios are held as numerator and denominator
`ifndef PRSD_CONSTS_SVH
`define PRSD_CONSTS_SVH

`define PRSD_FAB_W 4
`define PRSD_FAB_MULT_W 5
`define PRSD_VER_W 32
// version value is arbitrary; low byte is the mask revision
`define PRSD_VERSION_ID 32'h5a5a0001
`define PRSD_MASKREV_LSB 0
`define PRSD_MASKREV_W 8
// fabric codes
`define PRSD_FAB_16 4'h0
`define PRSD_FAB_2 4'h2
`define PRSD_FAB_3 4'h3
`define PRSD_FAB_4 4'h4
`define PRSD_FAB_5 4'h5
`define PRSD_FAB_6 4'h6
`define PRSD_FAB_8 4'h8
`define PRSD_FAB_9 4'h9
`define PRSD_FAB_10 4'ha
`define PRSD_FAB_12 4'hc
// core ratio numerators, halves of the fabric clock
`define PRSD_CORE_NUM_00 3'h4
`define PRSD_CORE_NUM_01 3'h5
`define PRSD_CORE_NUM_10 3'h6
`define PRSD_CORE_NUM_11 3'h7
`define PRSD_CORE_DEN 2'h2
// memory bus is fabric divided by this
`define PRSD_MEM_DIV 2'h2

`endif

// [prsd_pkg.sv]
// Purpose: types for the clock ratio strap decoder
// Assumes: nothing
// Notes: none
package prsd_pkg;
  typedef logic [3:0] prsd_fab_code_t;
  typedef logic [4:0] prsd_fab_mult_t;
  typedef logic [2:0] prsd_core_num_t;
  typedef enum logic [1:0] {
    PRSD_WAIT = 2'b00,
    PRSD_LATCH = 2'b01,
    PRSD_HOLD = 2'b10
  } prsd_state_e;
endpackage

// [prsd_fab_decode.sv]
// Purpose: decode fabric ratio code to multiplier
// Assumes: registered output, async reset
// Notes: reserved codes give zero and a flag
`timescale 1ns/1ps
`default_nettype none
`include "prsd_consts.svh"
module prsd_fab_decode (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire prsd_pkg::prsd_fab_code_t code_in,
  output prsd_pkg::prsd_fab_mult_t mult_out,
  output logic reserved_out
);
  import prsd_pkg::*;
  prsd_fab_mult_t next_mult;

  always_comb begin
    next_mult = 5'h00;
    case (code_in) // RQ2
      `PRSD_FAB_16: next_mult = 5'h10;
      `PRSD_FAB_2: next_mult = 5'h02;
      `PRSD_FAB_3: next_mult = 5'h03;
      `PRSD_FAB_4: next_mult = 5'h04;
      `PRSD_FAB_5: next_mult = 5'h05;
      `PRSD_FAB_6: next_mult = 5'h06;
      `PRSD_FAB_8: next_mult = 5'h08;
      `PRSD_FAB_9: next_mult = 5'h09;
      `PRSD_FAB_10: next_mult = 5'h0a;
      `PRSD_FAB_12: next_mult = 5'h0c;
      default: next_mult = 5'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mult_out <= 5'h00;
      reserved_out <= 1'b0;
    end else begin
      mult_out <= next_mult;
      reserved_out <= (next_mult == 5'h00);
    end
  end
endmodule
`default_nettype wire

// [prsd_top.sv]
// Purpose: latch and decode power-up clock ratio straps
// Assumes: straps synchronous to clock_in; reset_n_in is power-up reset
// Notes: ratios frozen after first capture until next reset
`timescale 1ns/1ps
`default_nettype none
`include "prsd_consts.svh"

// What this block does
// RQ1: the fabric multiplier comes from the four fabric straps at power up.
// RQ2: fabric codes map to 16,2..6,8..10,12 times; the rest are reserved.
// RQ3: the board must drive every fabric strap; there is no default.
// RQ4: two core straps, msb first, give 2:1, 5:2, 3:1 or 7:2 core:fabric.
// RQ5: memory bus runs at half fabric; DDR data rate equals fabric.
// RQ6: board keeps core between 400 MHz and its rated maximum.
// RQ7: board keeps the fabric clock at or above 200 MHz.
// RQ8: board keeps the memory bus between 100 and 166 MHz.
// RQ9: a read-only version code shows the die mask revision in its low part.
// RQ10: straps are latched once after reset and held until the next reset.
module prsd_top (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire prsd_pkg::prsd_fab_code_t fabric_ratio_straps_in,
  input wire logic core_ratio_msb_pin_in,
  input wire logic core_ratio_lsb_pin_in,
  output prsd_pkg::prsd_fab_mult_t fabric_mult_out,
  output logic fabric_reserved_out,
  output prsd_pkg::prsd_core_num_t core_num_out,
  output logic [1:0] core_den_out,
  output logic [1:0] mem_bus_div_out,
  output logic ddr_rate_eq_fabric_out,
  output logic ratios_valid_out,
  output logic [31:0] version_id_register_out,
  output logic [7:0] mask_revision_out
);
  import prsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // capture sequence
  prsd_state_e state;
  prsd_fab_code_t fab_code;
  logic [1:0] core_code;
  prsd_fab_mult_t dec_mult;
  logic dec_res;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= PRSD_WAIT;
    end else begin
      case (state)
        PRSD_WAIT: state <= PRSD_LATCH;
        PRSD_LATCH: state <= PRSD_HOLD;
        PRSD_HOLD: state <= PRSD_HOLD; // RQ10
        default: state <= PRSD_HOLD;
      endcase
    end
  end

  // straps sampled once, first edge after release
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fab_code <= 4'h1;
      core_code <= 2'h0;
    end else if (state == PRSD_WAIT) begin
      fab_code <= fabric_ratio_straps_in; // RQ1 RQ10
      core_code <= {core_ratio_msb_pin_in, core_ratio_lsb_pin_in}; // RQ4
    end
  end

  prsd_fab_decode u_fab (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .code_in(fab_code),
    .mult_out(dec_mult),
    .reserved_out(dec_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fabric_mult_out <= 5'h00;
      fabric_reserved_out <= 1'b0;
      ratios_valid_out <= 1'b0;
    end else if (state == PRSD_HOLD && !ratios_valid_out) begin
      fabric_mult_out <= dec_mult; // RQ1
      fabric_reserved_out <= dec_res; // RQ2
      ratios_valid_out <= 1'b1; // RQ10
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_num_out <= 3'h0;
      core_den_out <= 2'h0;
    end else if (state == PRSD_LATCH) begin
      case (core_code) // RQ4
        2'h0: core_num_out <= `PRSD_CORE_NUM_00;
        2'h1: core_num_out <= `PRSD_CORE_NUM_01;
        2'h2: core_num_out <= `PRSD_CORE_NUM_10;
        default: core_num_out <= `PRSD_CORE_NUM_11;
      endcase
      core_den_out <= `PRSD_CORE_DEN;
    end
  end

  localparam logic [31:0] version_id = `PRSD_VERSION_ID;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_bus_div_out <= 2'h0;
      ddr_rate_eq_fabric_out <= 1'b0;
      version_id_register_out <= 32'h0;
      mask_revision_out <= 8'h00;
    end else begin
      mem_bus_div_out <= `PRSD_MEM_DIV; // RQ5
      ddr_rate_eq_fabric_out <= 1'b1; // RQ5
      version_id_register_out <= version_id; // RQ9
      mask_revision_out <=
        version_id[`PRSD_MASKREV_LSB +: `PRSD_MASKREV_W]; // RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence capture_s;
    state == PRSD_WAIT ##1 state == PRSD_LATCH;
  endsequence

  sequence settle_s;
    state == PRSD_LATCH ##1 state == PRSD_HOLD;
  endsequence

  // expected multiplier per fabric code, zero where reserved
  localparam logic [4:0] fab_table [16] = '{
    5'h10, 5'h00, 5'h02, 5'h03,
    5'h04, 5'h05, 5'h06, 5'h00,
    5'h08, 5'h09, 5'h0a, 5'h00,
    5'h0c, 5'h00, 5'h00, 5'h00
  };

  state_walk_a: assert property ( // RQ10
    state == PRSD_WAIT |=> settle_s)
    else $error("capture sequence out of order");

  hold_stay_a: assert property ( // RQ10
    state == PRSD_HOLD |=> state == PRSD_HOLD)
    else $error("capture state left hold");

  fab_capture_a: assert property ( // RQ1
    state == PRSD_WAIT |=> fab_code == $past(fabric_ratio_straps_in))
    else $error("fabric straps not captured");

  core_capture_a: assert property ( // RQ4
    state == PRSD_WAIT |=>
      core_code[1] == $past(core_ratio_msb_pin_in) &&
      core_code[0] == $past(core_ratio_lsb_pin_in))
    else $error("core straps not captured");

  strap_ignore_a: assert property ( // RQ10
    state != PRSD_WAIT |=> $stable(fab_code) && $stable(core_code))
    else $error("straps taken after capture");

  fab_hold_a: assert property ( // RQ10
    ratios_valid_out |=> $stable(fabric_mult_out) && $stable(core_num_out))
    else $error("ratios changed after capture");

  res_hold_a: assert property ( // RQ10
    ratios_valid_out |=>
      $stable(fabric_reserved_out) && $stable(core_den_out))
    else $error("flags changed after capture");

  valid_stay_a: assert property ( // RQ10
    ratios_valid_out |=> ratios_valid_out)
    else $error("ratios valid dropped");

  mult_idle_a: assert property ( // RQ10
    !ratios_valid_out |-> fabric_mult_out == 5'h00)
    else $error("multiplier shown before capture");

  valid_time_a: assert property ( // RQ10
    capture_s |=> !ratios_valid_out ##1 ratios_valid_out)
    else $error("ratios not valid three cycles after reset");

  fab_map_a: assert property ( // RQ2
    $rose(ratios_valid_out) |->
      (fab_code == 4'h0) == (fabric_mult_out == 5'h10))
    else $error("code zero does not give sixteen");

  for (genvar k = 0; k < 16; k++) begin : g_fab_entry
    fab_entry_a: assert property ( // RQ1 RQ2
      $rose(ratios_valid_out) && fab_code == 4'(k) |->
        fabric_mult_out == fab_table[k])
      else $error("fabric multiplier wrong for code");
  end

  fab_res_a: assert property ( // RQ2
    $rose(ratios_valid_out) |->
      fabric_reserved_out == (fab_code inside {4'h1, 4'h7, 4'hb, 4'hd,
        4'he, 4'hf}))
    else $error("reserved flag wrong");

  reserved_zero_a: assert property ( // RQ2
    ratios_valid_out && fabric_reserved_out |-> fabric_mult_out == 5'h00)
    else $error("reserved code gives a multiplier");

  core_map_a: assert property ( // RQ4
    state == PRSD_HOLD |->
      core_num_out == 3'(3'h4 + {1'b0, core_code}))
    else $error("core ratio wrong");

  core_den_a: assert property ( // RQ4
    state == PRSD_HOLD |-> core_den_out == `PRSD_CORE_DEN)
    else $error("core denominator wrong");

  mem_half_a: assert property ( // RQ5
    ##1 1'b1 |-> mem_bus_div_out == 2'h2 && ddr_rate_eq_fabric_out)
    else $error("memory clock not half fabric");

  version_a: assert property ( // RQ9
    ##1 1'b1 |-> mask_revision_out == version_id_register_out[7:0])
    else $error("mask revision mismatch");

  version_fixed_a: assert property ( // RQ9
    ##1 1'b1 |-> version_id_register_out == `PRSD_VERSION_ID)
    else $error("version code wrong");
endmodule
`default_nettype wire

// [prsd_board_model.sv]
// Purpose: board strap network facing the ratio decoder
// Assumes: bench picks the codes the board straps
// Notes: every strap is driven, never left floating
`timescale 1ns/1ps
`default_nettype none
module prsd_board_model #(
  // reference clock and rated core maximum the board is built for
  parameter int ref_khz = 25000,
  parameter int core_max_khz = 1000000
) (
  input wire logic [3:0] fab_code_in,
  input wire logic [1:0] core_code_in,
  output logic [3:0] fabric_ratio_straps_out,
  output logic core_ratio_msb_pin_out,
  output logic core_ratio_lsb_pin_out,
  output logic range_ok_out
);
  int fab_mult;
  int fabric_khz;
  int core_khz;

  // all four fabric straps held at a level, bit3 first
  assign fabric_ratio_straps_out = fab_code_in;
  assign core_ratio_msb_pin_out = core_code_in[1];
  assign core_ratio_lsb_pin_out = core_code_in[0];

  // frequencies the chosen straps give on this board
  always_comb begin
    case (fab_code_in)
      4'h0: fab_mult = 16;
      4'h1, 4'h7, 4'hb, 4'hd, 4'he, 4'hf: fab_mult = 0;
      default: fab_mult = int'(fab_code_in);
    endcase
    fabric_khz = ref_khz * fab_mult;
    core_khz = fabric_khz * (4 + int'(core_code_in)) / 2;
    range_ok_out = (core_khz >= 400000) && (core_khz <= core_max_khz) &&
      (fabric_khz >= 200000) &&
      (fabric_khz / 2 >= 100000) && (fabric_khz / 2 <= 166000);
  end
endmodule
`default_nettype wire

// [prsd_testbench.sv]
// Purpose: self-checking bench for the ratio strap decoder
// Assumes: inputs driven at the falling edge
// Notes: each power-up walks the three capture edges
`timescale 1ns/1ps
`default_nettype none
`include "prsd_consts.svh"
module testbench;
  import prsd_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] fab_code = 4'h0;
  logic [1:0] core_code = 2'h0;
  wire logic [3:0] straps;
  wire logic msb;
  wire logic lsb;
  wire logic range_ok;
  prsd_fab_mult_t mult;
  prsd_core_num_t num;
  logic res, ddr, valid;
  logic [1:0] den, mdiv;
  logic [31:0] ver;
  logic [7:0] mrev;
  int bad_count = 0;
  int tests_run = 0;
  always #20 clock_in = ~clock_in;
  prsd_board_model i_prsd_board_model (.fab_code_in(fab_code),
    .core_code_in(core_code), .fabric_ratio_straps_out(straps),
    .core_ratio_msb_pin_out(msb), .core_ratio_lsb_pin_out(lsb),
    .range_ok_out(range_ok));
  prsd_top i_prsd_top (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .fabric_ratio_straps_in(straps), .core_ratio_msb_pin_in(msb),
    .core_ratio_lsb_pin_in(lsb), .fabric_mult_out(mult),
    .fabric_reserved_out(res), .core_num_out(num), .core_den_out(den),
    .mem_bus_div_out(mdiv), .ddr_rate_eq_fabric_out(ddr),
    .ratios_valid_out(valid), .version_id_register_out(ver),
    .mask_revision_out(mrev));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [4:0] exp_mult(input logic [3:0] c);
    case (c)
      4'h0: exp_mult = 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha: exp_mult = {1'b0, c};
      4'hc: exp_mult = 5'h0c;
      default: exp_mult = 5'h00;
    endcase
  endfunction
  task automatic close_out();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // power up with given straps, flip them after capture edge
  task automatic power_up(input logic [3:0] f, input logic [1:0] c);
    @(negedge clock_in);
    reset_n_in = 1'b0;
    fab_code = f;
    core_code = c;
    #1 check(32'(valid), 32'h0);
    check(32'(mult), 32'h0);
    repeat (2) @(negedge clock_in);
    reset_n_in = 1'b1;
    @(negedge clock_in);
    fab_code = ~f;
    core_code = ~c;
    check(32'(mdiv), 32'h2);
    check(32'(ddr), 32'h1);
    check(ver, 32'h5a5a0001);
    check(32'(mrev), 32'h01);
    @(negedge clock_in);
    check(32'(valid), 32'h0);
    check(32'(num), 32'(c) + 32'h4);
    check(32'(den), 32'h2);
    @(negedge clock_in);
    check(32'(valid), 32'h1);
    repeat (3) @(negedge clock_in);
    check(32'(mult), 32'(exp_mult(f)));
    check(32'(res), 32'(exp_mult(f) == 5'h0));
    check(32'(num), 32'(c) + 32'h4);
  endtask
  task automatic run_fabric_codes();
    for (int i = 0; i < 16; i++) power_up(4'(i), 2'(i));
  endtask
  task automatic run_core_codes();
    for (int i = 0; i < 4; i++) begin
      fab_code = 4'h9;
      core_code = 2'(i);
      #1 check(32'(range_ok), 32'h1);
      power_up(4'h9, 2'(i));
    end
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (4) @(negedge clock_in);
    run_fabric_codes();
    run_core_codes();
    close_out();
  end
endmodule
`default_nettype wire
